// >>> pcd_host.v
// Host sequencer for the protection and extended-block command sets of a flash.
// Assumes the flash keeps its own protection state; this side only issues cycles.
`include "pcd_consts.vh"
module pcd_host (
    clock,
    rst_n,
    byteMode,
    cmdValid,
    cmdReady,
    cmdOp,
    cmdAddr,
    cmdData,
    cmdPassword,
    rspValid,
    rspData,
    unlockWaiting,
    flashAddr,
    flashCeN,
    flashWeN,
    flashOeN,
    flashDqOut,
    flashDqOeN,
    flashDqIn
);
    input  wire        clock;
    input  wire        rst_n;
    input  wire        byteMode;
    input  wire        cmdValid;
    output wire        cmdReady;
    input  wire [3:0]  cmdOp;
    input  wire [25:0] cmdAddr;
    input  wire [15:0] cmdData;
    input  wire [63:0] cmdPassword;
    output reg         rspValid;
    output reg  [15:0] rspData;
    output wire        unlockWaiting;
    output wire [25:0] flashAddr;
    output wire        flashCeN;
    output wire        flashWeN;
    output wire        flashOeN;
    output wire [15:0] flashDqOut;
    output wire        flashDqOeN;
    input  wire [15:0] flashDqIn;

    // ----------------------------------------------------------------------
    // States
    // ----------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ISSUE = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;
    localparam [31:0] GAP_FULL = `PCD_UNLOCK_GAP_CYC;

    reg [3:0]  state_q;
    reg [3:0]  op_q;
    reg [25:0] addr_q;
    reg [15:0] data_q;
    reg [63:0] pwd_q;
    reg        x8_q;
    reg [3:0]  step_q;
    reg [15:0] gap_q;
    reg [15:0] rdLast_q;

    reg        cycStart;
    reg        cycRead;
    reg [25:0] cycAddr;
    reg [15:0] cycData;
    reg        lastStep;
    wire       cycDone;
    wire [15:0] cycRdData;
    wire [2:0] pwdIdx;

    assign cmdReady      = (state_q == ST_IDLE) &&
                           !(cmdOp == `PCD_OP_PWD_UNLOCK && gap_q != 16'h0);
    assign unlockWaiting = (gap_q != 16'h0);
    assign pwdIdx        = step_q[2:0] - 3'h2;

    // ----------------------------------------------------------------------
    // Cycle table: address, data and direction of each step
    // ----------------------------------------------------------------------
    always @*
    begin
        cycRead  = 1'b0;
        cycAddr  = `PCD_ADDR_ZERO;
        cycData  = 16'h0000;
        lastStep = 1'b0;
        case (op_q)
            `PCD_OP_ENTER_VOL, `PCD_OP_ENTER_EXT, `PCD_OP_EXT_PROG, `PCD_OP_EXIT_EXT:
            begin
                if (step_q == 4'h0)
                begin
                    cycAddr = x8_q ? `PCD_ADDR_X8_AAA : `PCD_ADDR_X16_555;
                    cycData = {8'h00, `PCD_DATA_AA};
                end
                else if (step_q == 4'h1)
                begin
                    cycAddr = x8_q ? `PCD_ADDR_X8_555 : `PCD_ADDR_X16_2AA;
                    cycData = {8'h00, `PCD_DATA_55};
                end
                else if (step_q == 4'h2)
                begin
                    if (op_q == `PCD_OP_EXIT_EXT)
                        cycAddr = x8_q ? `PCD_ADDR_X8_555 : `PCD_ADDR_X16_555;
                    else
                        cycAddr = x8_q ? `PCD_ADDR_X8_AAA : `PCD_ADDR_X16_555;
                    if (op_q == `PCD_OP_ENTER_VOL)
                        cycData = {8'h00, `PCD_CODE_VOLATILE};
                    else if (op_q == `PCD_OP_ENTER_EXT)
                        cycData = {8'h00, `PCD_CODE_EXTENDED};
                    else if (op_q == `PCD_OP_EXT_PROG)
                        cycData = {8'h00, `PCD_CODE_PROGRAM};
                    else
                        cycData = {8'h00, `PCD_CODE_EXIT1};
                    lastStep = (op_q == `PCD_OP_ENTER_VOL) || (op_q == `PCD_OP_ENTER_EXT);
                end
                else
                begin
                    cycAddr  = addr_q;
                    cycData  = (op_q == `PCD_OP_EXIT_EXT) ? {8'h00, `PCD_CODE_EXIT2} : data_q;
                    lastStep = 1'b1;
                end
            end
            `PCD_OP_EXIT_VOL:
            begin
                if (step_q == 4'h0)
                    cycData = {8'h00, `PCD_CODE_EXIT1};
                else
                    cycData = {8'h00, `PCD_CODE_EXIT2};
                lastStep = (step_q == 4'h1);
            end
            `PCD_OP_SET_BIT, `PCD_OP_CLR_BIT, `PCD_OP_PWD_PROG:
            begin
                cycAddr  = (step_q == 4'h0) ? `PCD_ADDR_ZERO : addr_q;
                if (step_q == 4'h0)
                    cycData = {8'h00, `PCD_CODE_PROGRAM};
                else if (op_q == `PCD_OP_SET_BIT)
                    cycData = {8'h00, `PCD_CODE_PROTECT};
                else if (op_q == `PCD_OP_CLR_BIT)
                    cycData = {8'h00, `PCD_CODE_UNPROT};
                else
                    cycData = data_q;
                lastStep = (step_q == 4'h1);
            end
            `PCD_OP_READ:
            begin
                cycRead  = 1'b1;
                cycAddr  = addr_q;
                lastStep = 1'b1;
            end
            `PCD_OP_PWD_UNLOCK:
            begin
                if (step_q == 4'h0)
                    cycData = {8'h00, `PCD_CODE_UNLK1};
                else if (step_q == 4'h1)
                    cycData = {8'h00, `PCD_CODE_UNLK2};
                else if (step_q == (x8_q ? 4'ha : 4'h6))
                begin
                    cycData  = {8'h00, `PCD_CODE_UNLK3};
                    lastStep = 1'b1;
                end
                else
                begin
                    // Portions walk upward from index 0
                    if (x8_q)
                    begin
                        cycAddr = {23'h000000, pwdIdx};
                        cycData = {8'h00, pwd_q[pwdIdx * 8 +: 8]};
                    end
                    else
                    begin
                        cycAddr = {24'h000000, pwdIdx[1:0]};
                        cycData = pwd_q[pwdIdx[1:0] * 16 +: 16];
                    end
                end
            end
            default:
            begin
                lastStep = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------------
    always @*
    begin
        cycStart = (state_q == ST_ISSUE);
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q  <= ST_IDLE;
            op_q     <= 4'h0;
            addr_q   <= 26'h0000000;
            data_q   <= 16'h0000;
            pwd_q    <= 64'h0000000000000000;
            x8_q     <= 1'b0;
            step_q   <= 4'h0;
            gap_q    <= 16'h0000;
            rspValid <= 1'b0;
            rspData  <= 16'h0000;
            rdLast_q <= 16'h0000;
        end
        else
        begin
            rspValid <= 1'b0;
            if (gap_q != 16'h0)
                gap_q <= gap_q - 16'h1;
            case (state_q)
                ST_IDLE:
                begin
                    if (cmdValid && cmdReady)
                    begin
                        op_q    <= cmdOp;
                        addr_q  <= cmdAddr;
                        data_q  <= cmdData;
                        pwd_q   <= cmdPassword;
                        x8_q    <= byteMode;
                        step_q  <= 4'h0;
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE:
                begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (cycDone)
                    begin
                        rdLast_q <= cycRdData;
                        if (lastStep)
                            state_q <= ST_DONE;
                        else
                        begin
                            step_q  <= step_q + 4'h1;
                            state_q <= ST_ISSUE;
                        end
                    end
                end
                ST_DONE:
                begin
                    rspValid <= 1'b1;
                    rspData  <= rdLast_q;
                    // Spacing counts from the end of the closing cycle
                    if (op_q == `PCD_OP_PWD_UNLOCK)
                        gap_q <= GAP_FULL[15:0];
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    pcd_bus_cycle u_cycle (
        .clock      (clock),
        .rst_n      (rst_n),
        .start      (cycStart),
        .isRead     (cycRead),
        .addrIn     (cycAddr),
        .dataIn     (cycData),
        .busy       (),
        .done       (cycDone),
        .readData   (cycRdData),
        .flashAddr  (flashAddr),
        .flashCeN   (flashCeN),
        .flashWeN   (flashWeN),
        .flashOeN   (flashOeN),
        .flashDqOut (flashDqOut),
        .flashDqOeN (flashDqOeN),
        .flashDqIn  (flashDqIn)
    );
endmodule // pcd_host

// >>> pcd_consts.vh
// Constants for the protection command host sequencer.
// Assumes a parallel flash bus strobed by chip select, write enable, output enable.
`ifndef PCD_CONSTS_VH
`define PCD_CONSTS_VH
// --------------------------------------------------------------------------
// Unlock addresses and data
// --------------------------------------------------------------------------
`define PCD_ADDR_X8_AAA   26'h0000aaa
`define PCD_ADDR_X8_555   26'h0000555
`define PCD_ADDR_X16_555  26'h0000555
`define PCD_ADDR_X16_2AA  26'h00002aa
`define PCD_ADDR_ZERO     26'h0000000
`define PCD_DATA_AA       8'haa
`define PCD_DATA_55       8'h55
// --------------------------------------------------------------------------
// Command codes
// --------------------------------------------------------------------------
`define PCD_CODE_VOLATILE 8'he0
`define PCD_CODE_EXTENDED 8'h88
`define PCD_CODE_PROGRAM  8'ha0
`define PCD_CODE_EXIT1    8'h90
`define PCD_CODE_EXIT2    8'h00
`define PCD_CODE_PROTECT  8'h00
`define PCD_CODE_UNPROT   8'h01
`define PCD_CODE_UNLK1    8'h25
`define PCD_CODE_UNLK2    8'h03
`define PCD_CODE_UNLK3    8'h29
// --------------------------------------------------------------------------
// Operations at the user port
// --------------------------------------------------------------------------
`define PCD_OP_ENTER_VOL  4'h0
`define PCD_OP_ENTER_EXT  4'h1
`define PCD_OP_EXIT_VOL   4'h2
`define PCD_OP_EXIT_EXT   4'h3
`define PCD_OP_SET_BIT    4'h4
`define PCD_OP_CLR_BIT    4'h5
`define PCD_OP_READ       4'h6
`define PCD_OP_PWD_PROG   4'h7
`define PCD_OP_PWD_UNLOCK 4'h8
`define PCD_OP_EXT_PROG   4'h9
// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define PCD_CLK_MHZ        250
`define PCD_PHASE_CYC      4
`define PCD_UNLOCK_GAP_NS  6000
`define PCD_UNLOCK_GAP_CYC ((`PCD_UNLOCK_GAP_NS * `PCD_CLK_MHZ + 999) / 1000)
`endif

// >>> pcd_bus_cycle.v
// One flash bus cycle: a write or a read strobe of fixed phase length.
// Assumes the flash samples on the rising edge of its write or output enable.
`include "pcd_consts.vh"
module pcd_bus_cycle (
    clock,
    rst_n,
    start,
    isRead,
    addrIn,
    dataIn,
    busy,
    done,
    readData,
    flashAddr,
    flashCeN,
    flashWeN,
    flashOeN,
    flashDqOut,
    flashDqOeN,
    flashDqIn
);
    input  wire        clock;
    input  wire        rst_n;
    input  wire        start;
    input  wire        isRead;
    input  wire [25:0] addrIn;
    input  wire [15:0] dataIn;
    output wire        busy;
    output reg         done;
    output reg  [15:0] readData;
    output reg  [25:0] flashAddr;
    output reg         flashCeN;
    output reg         flashWeN;
    output reg         flashOeN;
    output reg  [15:0] flashDqOut;
    output reg         flashDqOeN;
    input  wire [15:0] flashDqIn;

    // ----------------------------------------------------------------------
    // Data pin synchroniser
    // ----------------------------------------------------------------------
    reg [15:0] dqMeta_q;
    reg [15:0] dqSync_q;
    reg [3:0]  phase_q;
    reg        rd_q;

    assign busy = (phase_q != 4'h0);

    always @(posedge clock)
    begin
        dqMeta_q <= flashDqIn;
        dqSync_q <= dqMeta_q;
    end

    // ----------------------------------------------------------------------
    // Strobe sequencing: setup, strobe low, hold, release
    // ----------------------------------------------------------------------
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            phase_q    <= 4'h0;
            rd_q       <= 1'b0;
            done       <= 1'b0;
            readData   <= 16'h0000;
            flashAddr  <= 26'h0000000;
            flashCeN   <= 1'b1;
            flashWeN   <= 1'b1;
            flashOeN   <= 1'b1;
            flashDqOut <= 16'h0000;
            flashDqOeN <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            if (phase_q == 4'h0)
            begin
                if (start)
                begin
                    phase_q    <= 4'h1;
                    rd_q       <= isRead;
                    flashAddr  <= addrIn;
                    flashDqOut <= dataIn;
                    flashCeN   <= 1'b0;
                    // A read cycle never drives the data pins
                    flashDqOeN <= isRead;
                end
            end
            else
            begin
                phase_q <= phase_q + 4'h1;
                if (phase_q == 4'h1)
                begin
                    flashWeN <= rd_q;
                    flashOeN <= ~rd_q;
                end
                if (phase_q == 4'h1 + `PCD_PHASE_CYC)
                begin
                    flashWeN <= 1'b1;
                    flashOeN <= 1'b1;
                    if (rd_q)
                        readData <= dqSync_q;
                end
                if (phase_q == 4'h2 + `PCD_PHASE_CYC)
                begin
                    flashCeN   <= 1'b1;
                    flashDqOeN <= 1'b1;
                    phase_q    <= 4'h0;
                    done       <= 1'b1;
                end
            end
        end
    end
endmodule // pcd_bus_cycle

// >>> pcd_host_asserts.sv
// Pin-level checks on the protection command host sequencer.
// Assumes one clock and the synchronous active-low reset.
module pcd_host_asserts (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  cmdOp,
    input wire logic        cmdReady,
    input wire logic        rspValid,
    input wire logic        unlockWaiting,
    input wire logic [25:0] flashAddr,
    input wire logic        flashCeN,
    input wire logic        flashWeN,
    input wire logic        flashOeN,
    input wire logic        flashDqOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [11:0] gapCnt_q;
    // Saturates so a stuck wait cannot wrap into a false fail
    always @(posedge clock)
        if (!rst_n || !unlockWaiting)
            gapCnt_q <= 12'h000;
        else if (gapCnt_q != 12'hfff)
            gapCnt_q <= gapCnt_q + 12'h001;
    sequence weLow4;
        !flashWeN[*4] ##1 flashWeN;
    endsequence
    sequence oeLow4;
        !flashOeN[*4] ##1 flashOeN;
    endsequence
    chk_we_width: assert property ($fell(flashWeN) |-> weLow4)
        else $error("write strobe not four cycles");
    chk_oe_width: assert property ($fell(flashOeN) |-> oeLow4)
        else $error("read strobe not four cycles");
    chk_strobe_excl: assert property (!(!flashWeN && !flashOeN))
        else $error("both strobes low");
    chk_read_release: assert property (!flashOeN |-> flashDqOeN && !flashCeN)
        else $error("data driven in a read");
    chk_write_drive: assert property (!flashWeN |-> !flashDqOeN && !flashCeN)
        else $error("write without data or select");
    chk_addr_hold: assert property (!flashCeN && $past(!flashCeN) |->
        $stable(flashAddr))
        else $error("address moved in a cycle");
    chk_ce_setup: assert property ($fell(flashWeN) || $fell(flashOeN) |->
        $past(!flashCeN))
        else $error("strobe before select");
    chk_rsp_idle: assert property (rspValid |-> flashCeN ##1 !rspValid)
        else $error("response during a cycle or too long");
    chk_unlock_hold: assert property (unlockWaiting && cmdOp == 4'h8 |-> !cmdReady)
        else $error("unlock taken too early");
    chk_unlock_gap: assert property ($fell(unlockWaiting) |-> gapCnt_q >= 12'h5db)
        else $error("unlock spacing too short");
endmodule // pcd_host_asserts

bind pcd_host pcd_host_asserts u_chk (.clock, .rst_n, .cmdOp, .cmdReady, .rspValid,
    .unlockWaiting, .flashAddr, .flashCeN, .flashWeN, .flashOeN, .flashDqOeN);

// >>> pcd_flash_model.sv
// Behavioural flash device on the far side of the host sequencer.
// Assumes writes land on the rising write strobe under chip select.
module pcd_flash_model #(
    parameter logic [15:0] BLOCKED_DATA = 16'h0bad
) (
    input  wire logic        byteMode,
    input  wire logic [25:0] addr,
    input  wire logic        ceN,
    input  wire logic        weN,
    input  wire logic        oeN,
    input  wire logic [15:0] dqOut,
    input  wire logic        dqOeN,
    output logic      [15:0] dqIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [41:0] wrLog[$];
    logic [1:0]  mode;
    logic [1:0]  step;
    logic        progArm;
    logic        exitArm;
    logic [7:0]  volBit;
    logic [15:0] extMem[0:255];
    logic [15:0] rd;
    logic [15:0] held;
    logic [7:0]  d;
    initial
    begin
        {mode, step, progArm, exitArm} = 6'h00;
        volBit = 8'hff;
        held = 16'h0000;
        foreach (extMem[i]) extMem[i] = 16'hffff;
    end
    always @(posedge weN)
        if (!ceN && !dqOeN)
        begin
            d = dqOut[7:0];
            wrLog.push_back({addr, dqOut});
            if (progArm)
            begin
                progArm = 1'b0;
                if (mode == 2'h1) volBit[addr[18:16]] = d[0];
                // Programming only clears bits, so each bit goes once
                if (mode == 2'h2) extMem[addr[7:0]] &= dqOut;
            end
            else if (exitArm)
            begin
                exitArm = 1'b0;
                if (d == 8'h00) mode = 2'h0;
            end
            else if (mode == 2'h1 && (d == 8'h90 || d == 8'ha0))
                {exitArm, progArm} = {d == 8'h90, d == 8'ha0};
            else if (step == 2'h2)
            begin
                step = 2'h0;
                if (d == 8'he0) mode = 2'h1;
                if (d == 8'h88) mode = 2'h2;
                progArm = (d == 8'ha0) && mode == 2'h2;
                exitArm = (d == 8'h90) && mode == 2'h2;
            end
            else if (d == 8'haa && addr[15:0] == (byteMode ? 16'h0aaa : 16'h0555))
                step = 2'h1;
            else if (step == 2'h1 && d == 8'h55 && addr[15:0] == (byteMode ? 16'h0555 : 16'h02aa))
                step = 2'h2;
            else
                step = 2'h0;
        end
    always @*
        if (mode == 2'h2 && addr[25:16] == 10'h000)
            rd = extMem[addr[7:0]];
        else if (mode == 2'h1 && addr[25:16] == 10'h000)
            rd = BLOCKED_DATA;
        else if (mode == 2'h1)
            rd = {15'h0000, volBit[addr[18:16]]};
        else
            rd = addr[15:0] ^ 16'h5a5a;
    // A released bus shows the inverse of the last value, never a stale copy
    always @(posedge oeN) held = rd;
    assign dqIn = (!ceN && !oeN) ? rd : ~held;
endmodule // pcd_flash_model

// >>> pcd_host_test.sv
// Self-checking bench for the protection command host sequencer.
// Assumes the flash model logs every write it sees.
module pcd_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0;
    logic        rst_n = 0;
    logic        byteMode = 1;
    logic        cmdValid = 0;
    logic [3:0]  cmdOp = 4'h0;
    logic [25:0] cmdAddr = 26'h0000000;
    logic [15:0] cmdData = 16'h0000;
    logic [63:0] pw = 64'h1122334455667788;
    logic        cmdReady, rspValid, unlockWaiting, flashCeN, flashWeN, flashOeN, flashDqOeN;
    logic [15:0] rspData, flashDqOut, flashDqIn;
    logic [25:0] flashAddr;
    int          n_errors = 0;
    int          num_checks = 0;
    int          gap;
    always #2 clock = ~clock;
    pcd_host u_dut (.clock, .rst_n, .byteMode, .cmdValid, .cmdReady, .cmdOp, .cmdAddr,
        .cmdData, .cmdPassword(pw), .rspValid, .rspData, .unlockWaiting, .flashAddr,
        .flashCeN, .flashWeN, .flashOeN, .flashDqOut, .flashDqOeN, .flashDqIn);
    pcd_flash_model u_flash (.byteMode, .addr(flashAddr), .ceN(flashCeN), .weN(flashWeN),
        .oeN(flashOeN), .dqOut(flashDqOut), .dqOeN(flashDqOeN), .dqIn(flashDqIn));
    task automatic close_out;
        $display("Mismatches %0d of %0d checks", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkWr(input int i, input logic [25:0] a, input logic [15:0] d,
                         input logic [15:0] m = 16'h00ff);
        logic [41:0] e;
        e = (i < u_flash.wrLog.size()) ? u_flash.wrLog[i] : 'x;
        num_checks++;
        if (e[41:16] !== a || (e[15:0] & m) !== (d & m))
        begin
            n_errors++;
            $display("Error %0t write %0d was %h expected %h/%h", $time, i, e, a, d);
        end
    endtask
    task automatic doCmd(input logic [3:0] op, input logic [25:0] a, input logic [15:0] d);
        u_flash.wrLog.delete();
        @(posedge clock);
        {cmdValid, cmdOp, cmdAddr, cmdData} <= {1'b1, op, a, d};
        // Ready is judged at the edge that samples the request, after it has landed
        gap = 0;
        @(posedge clock);
        while (cmdReady !== 1'b1 && gap < 4000)
        begin
            @(posedge clock);
            gap++;
        end
        cmdValid <= 1'b0;
        for (int k = 0; k < 300 && rspValid !== 1'b1; k++) @(negedge clock);
        if (gap == 4000 || rspValid !== 1'b1)
        begin
            n_errors++;
            $display("Error %0t command %h hung", $time, op);
            close_out;
        end
    endtask
    task automatic readChk(input logic [25:0] a, input logic [15:0] exp);
        doCmd(4'h6, a, 16'h0000);
        chk(rspData, exp);
        chk(16'(u_flash.wrLog.size()), 16'h0000);
    endtask
    task automatic t_enter;
        for (int w = 1; w >= 0; w--)
        begin
            @(posedge clock) byteMode <= w[0];
            doCmd(4'h0, 26'h0, 16'h0);
            chkWr(0, w ? 26'haaa : 26'h555, 16'haa);
            chkWr(1, w ? 26'h555 : 26'h2aa, 16'h55);
            chkWr(2, w ? 26'haaa : 26'h555, 16'he0);
            doCmd(4'h2, 26'h0, 16'h0);
            chkWr(0, 26'h0, 16'h90);
            chkWr(1, 26'h0, 16'h00);
        end
    endtask
    task automatic t_volatile;
        @(posedge clock) byteMode <= 1'b1;
        doCmd(4'h0, 26'h0, 16'h0);
        doCmd(4'h4, 26'h31234, 16'h0);
        chkWr(0, 26'h0, 16'ha0);
        chkWr(1, 26'h31234, 16'h00);
        readChk(26'h30000, 16'h0000);
        readChk(26'h50010, 16'h0001);
        readChk(26'h00100, 16'h0bad);
        doCmd(4'h5, 26'h3ffff, 16'h0);
        chkWr(1, 26'h3ffff, 16'h01);
        readChk(26'h30002, 16'h0001);
        doCmd(4'h2, 26'h0, 16'h0);
        readChk(26'h30002, 16'h5a58);
    endtask
    task automatic t_ext;
        doCmd(4'h1, 26'h0, 16'h0);
        chkWr(2, 26'haaa, 16'h88);
        doCmd(4'h9, 26'h10, 16'h1234);
        chkWr(2, 26'haaa, 16'ha0);
        chkWr(3, 26'h10, 16'h1234, 16'hffff);
        readChk(26'h10, 16'h1234);
        doCmd(4'h3, 26'h0, 16'h0);
        chkWr(1, 26'h555, 16'h55);
        chkWr(2, 26'h555, 16'h90);
        chkWr(3, 26'h0, 16'h00);
        readChk(26'h10, 16'h5a4a);
    endtask
    task automatic t_password;
        doCmd(4'h7, 26'h3, 16'h00c3);
        chkWr(1, 26'h3, 16'hc3);
        chk(16'(u_flash.wrLog.size()), 16'h0002);
        for (int i = 7; i >= 0; i--)
        begin
            doCmd(4'h7, 26'(i), 16'(pw[8*i+:8]));
            chkWr(1, 26'(i), 16'(pw[8*i+:8]), 16'hffff);
        end
        for (int i = 0; i < 8; i++)
            readChk(26'(i), 16'(i) ^ 16'h5a5a);
        for (int w = 1; w >= 0; w--)
        begin
            @(posedge clock) byteMode <= w[0];
            doCmd(4'h8, 26'h0, 16'h0);
            if (w == 0)
                chk({15'h0, gap >= 1490 && gap < 1510}, 16'h0001);
            chk(16'(u_flash.wrLog.size()), w ? 16'h000b : 16'h0007);
            chkWr(0, 26'h0, 16'h25);
            chkWr(1, 26'h0, 16'h03);
            for (int i = 0; i < (w ? 8 : 4); i++)
                chkWr(i + 2, 26'(i), w ? 16'(pw[8*i+:8]) : pw[16*i+:16], 16'hffff);
            chkWr(w ? 10 : 6, 26'h0, 16'h29);
        end
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_enter;
        t_volatile;
        t_ext;
        t_password;
        close_out;
    end
endmodule // pcd_host_test
